// *** verilog/control_mode_pkg.sv ***
// Shared constants and types for the control mode and configuration select block.
// Assumes a single 20 MHz clock and a synchronous active low reset.
`default_nettype none

package control_mode_pkg;

   // ****************************************
   // Clock and pin decode
   // ****************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int NUM_TRI_PINS = 3;
   localparam int PIN_MODE = 0;   // Range or mode select pin
   localparam int PIN_RATE = 1;   // Output transition pin
   localparam int PIN_DELAY = 2;  // Calibration delay or dual-edge pin
   localparam int SETTLE_CYCLES = 4;

   typedef enum logic [1:0] {
      PIN_LOW = 2'b00,
      PIN_HIGH = 2'b01,
      PIN_FLOAT = 2'b10
   } pin_level_e;

   typedef enum logic [1:0] {
      MODE_WAIT = 2'b00,
      MODE_SETTLE = 2'b01,
      MODE_NORMAL = 2'b10,
      MODE_EXTENDED = 2'b11
   } ctrl_mode_e;

   // ****************************************
   // Serial frame
   // ****************************************
   localparam int FRAME_BITS = 32;
   localparam int HEADER_BITS = 12;
   localparam logic [11:0] FRAME_HEADER = 12'h001;

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [3:0] ADDR_CONFIG = 4'h1;
   localparam logic [3:0] ADDR_OFFSET_I = 4'h2;
   localparam logic [3:0] ADDR_FS_I = 4'h3;
   localparam logic [3:0] ADDR_OFFSET_Q = 4'hA;
   localparam logic [3:0] ADDR_FS_Q = 4'hB;
   localparam logic [3:0] ADDR_DES = 4'hD;
   localparam logic [3:0] ADDR_COARSE = 4'hE;
   localparam logic [3:0] ADDR_FINE = 4'hF;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CFG_DCS_BIT = 12;
   localparam int CFG_DDR_PHASE_BIT = 11;
   localparam int CFG_DDR_OFF_BIT = 10;   // Active low double rate enable
   localparam int CFG_SWING_BIT = 9;
   localparam int CFG_OE_BIT = 8;
   localparam int ADJ_MSB = 15;
   localparam int ADJ_LSB = 7;
   localparam int DES_EN_BIT = 15;
   localparam int DES_AUTO_BIT = 14;
   localparam int DES_QSEL_BIT = 13;

   // ****************************************
   // Power-on values
   // ****************************************
   localparam logic [15:0] CONFIG_RST = 16'hB2FF;
   localparam logic [15:0] OFFSET_RST = 16'h007F;
   localparam logic [15:0] FS_RST = 16'h807F;
   localparam logic [15:0] DES_RST = 16'h3FFF;
   localparam logic [15:0] PHASE_RST = 16'h0000;
   localparam logic [8:0] ZERO_ADJ = 9'h000;

   typedef struct packed {
      logic strobe;
      logic [3:0] addr;
      logic [15:0] data;
   } reg_write_s;

   typedef struct packed {
      logic ddr_en;
      logic ddr_phase_90;
      logic sdr_rising_edge;
      logic swing_normal;
      logic cal_delay_long;
      logic duty_stab_en;
      logic fs_from_pin;
      logic fs_pin_high;
      logic [8:0] fs_code_i;
      logic [8:0] fs_code_q;
      logic offset_en;
      logic [8:0] offset_code_i;
      logic [8:0] offset_code_q;
      logic des_en;
      logic des_q_channel;
      logic des_auto_phase;
      logic [15:0] phase_coarse;
      logic [15:0] phase_fine;
   } feature_s;

endpackage

`default_nettype wire

// *** verilog/tristate_pin_decoder.sv ***
// Decodes three-state strap pins into low, high or floating levels.
// Each pad supplies two sense comparators: above-high and below-low threshold.
`default_nettype none

module tristate_pin_decoder #(
   parameter int PINS = 3
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [PINS-1:0] sense_high,
   input wire logic [PINS-1:0] sense_low,
   output control_mode_pkg::pin_level_e level [PINS]
);

   // ****************************************
   // Per-pin level decode
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_pin
         wire logic is_high;
         wire logic is_low;
         assign is_high = sense_high[gi] & ~sense_low[gi];
         assign is_low = sense_low[gi] & ~sense_high[gi];
         always_ff @(posedge sys_clk) begin
            if (!rst_n) level[gi] <= control_mode_pkg::PIN_FLOAT;
            else if (is_high) level[gi] <= control_mode_pkg::PIN_HIGH;
            else if (is_low) level[gi] <= control_mode_pkg::PIN_LOW;
            else level[gi] <= control_mode_pkg::PIN_FLOAT;
         end
      end
   endgenerate

endmodule // tristate_pin_decoder

`default_nettype wire

// *** verilog/serial_frame_loader.sv ***
// Shifts in 32-bit write frames from the three-wire serial link.
// Serial pins are synchronous to sys_clk; the serial clock is sampled as data.
`default_nettype none

module serial_frame_loader (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic serial_select_n,
   output control_mode_pkg::reg_write_s wr
);

   logic sclk_prev;
   logic [31:0] shift;
   logic [5:0] count;

   wire logic rise;
   wire logic [31:0] next_shift;
   wire logic frame_done;
   wire logic header_ok;

   // Rising serial clock while selected
   assign rise = enable & ~serial_select_n & serial_clk & ~sclk_prev;
   assign next_shift = {shift[30:0], serial_data};
   assign frame_done = rise && (count == 6'(control_mode_pkg::FRAME_BITS - 1));
   assign header_ok = next_shift[31:20] == control_mode_pkg::FRAME_HEADER;

   // ****************************************
   // Shift and count
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sclk_prev <= 1'b0;
         shift <= 32'h0000_0000;
         count <= 6'h00;
      end else begin
         sclk_prev <= serial_clk;
         if (serial_select_n || !enable) count <= 6'h00;
         else if (frame_done) count <= 6'h00;  // Next frame from bit 0
         else if (rise) count <= count + 6'h01;
         if (rise) shift <= next_shift;
      end
   end

   // ****************************************
   // Write strobe, one cycle
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr <= '0;
      end else begin
         wr.strobe <= frame_done & header_ok;
         if (frame_done) begin
            wr.addr <= next_shift[19:16];
            wr.data <= next_shift[15:0];
         end
      end
   end

endmodule // serial_frame_loader

`default_nettype wire

// *** verilog/control_mode_config_select.sv ***
// Selects normal pin control or extended register control and routes every feature.
// Strap pins arrive as sense comparator pairs; the serial link is synchronous to sys_clk.
//
// Overview of operation
// - Floating range/mode pin selects extended mode; driven pin selects normal mode.
// - Extended mode takes configuration from serially loaded registers, not pins.
// - Normal mode: transition pin floating gives DDR, driven gives SDR.
// - Extended mode: DDR chosen by active-low bit 10 of register 1h.
// - Normal mode DDR clock phase is always zero degrees.
// - Extended mode DDR phase follows bit 11 of register 1h.
// - Normal SDR: transition pin high gives rising edge, low falling.
// - Extended SDR transition edge follows bit 8 of register 1h.
// - Swing from swing pin in normal mode, bit 9 in extended.
// - Calibration delay from delay pin in normal mode; extended always short.
// - Normal mode pin picks 650 or 870 mV range for both channels.
// - Extended full scale from bits 15 to 7 of register 3h (I) and Bh (Q).
// - Offset off in normal mode; extended uses bits 15 to 7 of 2h (I) and Ah (Q).
// - Dual-edge sampling enabled by pin in normal mode, register Dh extended.
// - Normal dual-edge uses I input only; extended may choose I or Q.
// - Normal auto phase always; extended auto phase from bit 14 of Dh.
// - Extended mode allows manual coarse and fine phase from Eh and Fh.
// - Extended reset defaults: DDR, zero phase, normal swing, short delay.
// - Extended reset defaults: nominal full scale, zero offset, dual-edge off.
// - Registers have no effect while normal mode is selected.
// - Serial writes are 32-bit msb-first frames: header, address, data.
`default_nettype none

module control_mode_config_select (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [control_mode_pkg::NUM_TRI_PINS-1:0] pin_sense_high,
   input wire logic [control_mode_pkg::NUM_TRI_PINS-1:0] pin_sense_low,
   input wire logic output_swing_sel,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic serial_select_n,
   output logic mode_valid,
   output logic mode_extended,
   output control_mode_pkg::feature_s features
);

   // ****************************************
   // Declarations
   // ****************************************
   control_mode_pkg::pin_level_e level [control_mode_pkg::NUM_TRI_PINS];
   control_mode_pkg::reg_write_s wr;
   control_mode_pkg::ctrl_mode_e mode;
   control_mode_pkg::ctrl_mode_e next_mode;
   control_mode_pkg::feature_s next_features;
   control_mode_pkg::feature_s pin_features;
   control_mode_pkg::feature_s reg_features;
   logic [2:0] settle_count;
   logic [15:0] regs [16];

   wire logic is_extended;
   wire logic settled;
   wire logic mode_pin_float;
   wire logic rate_pin_float;
   wire logic rate_pin_high;
   wire logic delay_pin_float;
   wire logic delay_pin_high;
   wire logic range_pin_high;
   wire logic [15:0] cfg;
   wire logic [15:0] des;

   // ****************************************
   // Strap pin decode
   // ****************************************
   tristate_pin_decoder #(
      .PINS(control_mode_pkg::NUM_TRI_PINS)
   ) u_pins (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .sense_high(pin_sense_high),
      .sense_low(pin_sense_low),
      .level(level)
   );

   assign mode_pin_float = level[control_mode_pkg::PIN_MODE] == control_mode_pkg::PIN_FLOAT;
   assign range_pin_high = level[control_mode_pkg::PIN_MODE] == control_mode_pkg::PIN_HIGH;
   assign rate_pin_float = level[control_mode_pkg::PIN_RATE] == control_mode_pkg::PIN_FLOAT;
   assign rate_pin_high = level[control_mode_pkg::PIN_RATE] == control_mode_pkg::PIN_HIGH;
   assign delay_pin_float = level[control_mode_pkg::PIN_DELAY] == control_mode_pkg::PIN_FLOAT;
   assign delay_pin_high = level[control_mode_pkg::PIN_DELAY] == control_mode_pkg::PIN_HIGH;

   // ****************************************
   // Mode latch
   // ****************************************
   assign settled = settle_count == 3'(control_mode_pkg::SETTLE_CYCLES - 1);
   assign is_extended = mode == control_mode_pkg::MODE_EXTENDED;

   // Next mode; once chosen it holds until reset
   always_comb begin
      next_mode = mode;
      case (mode)
         control_mode_pkg::MODE_WAIT: begin
            next_mode = control_mode_pkg::MODE_SETTLE;
         end
         control_mode_pkg::MODE_SETTLE: begin
            if (settled && mode_pin_float) next_mode = control_mode_pkg::MODE_EXTENDED;
            else if (settled) next_mode = control_mode_pkg::MODE_NORMAL;
         end
         control_mode_pkg::MODE_NORMAL: next_mode = control_mode_pkg::MODE_NORMAL;
         control_mode_pkg::MODE_EXTENDED: next_mode = control_mode_pkg::MODE_EXTENDED;
         default: next_mode = control_mode_pkg::MODE_WAIT;
      endcase
   end

   // Mode state and settle counter
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode <= control_mode_pkg::MODE_WAIT;
         settle_count <= 3'h0;
      end else begin
         mode <= next_mode;
         if (mode == control_mode_pkg::MODE_SETTLE && !settled) settle_count <= settle_count + 3'h1;
      end
   end

   // ****************************************
   // Serial register file
   // ****************************************
   // frame decode, only in extended mode
   serial_frame_loader u_loader (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(is_extended),
      .serial_clk(serial_clk),
      .serial_data(serial_data),
      .serial_select_n(serial_select_n),
      .wr(wr)
   );

   genvar ga;
   generate
      for (ga = 0; ga < 16; ga++) begin : g_reg
         localparam logic [3:0] A = 4'(ga);
         localparam logic mapped = A == control_mode_pkg::ADDR_CONFIG
            || A == control_mode_pkg::ADDR_OFFSET_I || A == control_mode_pkg::ADDR_FS_I
            || A == control_mode_pkg::ADDR_OFFSET_Q || A == control_mode_pkg::ADDR_FS_Q
            || A == control_mode_pkg::ADDR_DES || A == control_mode_pkg::ADDR_COARSE
            || A == control_mode_pkg::ADDR_FINE;
         localparam logic [15:0] RST =
            (A == control_mode_pkg::ADDR_CONFIG) ? control_mode_pkg::CONFIG_RST :
            (A == control_mode_pkg::ADDR_OFFSET_I || A == control_mode_pkg::ADDR_OFFSET_Q)
               ? control_mode_pkg::OFFSET_RST :
            (A == control_mode_pkg::ADDR_FS_I || A == control_mode_pkg::ADDR_FS_Q)
               ? control_mode_pkg::FS_RST :
            (A == control_mode_pkg::ADDR_DES) ? control_mode_pkg::DES_RST :
            control_mode_pkg::PHASE_RST;
         wire logic hit;
         // registers loaded over the serial link; reserved addresses ignored
         assign hit = mapped && wr.strobe && wr.addr == A;
         always_ff @(posedge sys_clk) begin
            if (!rst_n) regs[ga] <= RST;
            else if (hit) regs[ga] <= wr.data;
         end
      end
   endgenerate

   assign cfg = regs[control_mode_pkg::ADDR_CONFIG];
   assign des = regs[control_mode_pkg::ADDR_DES];

   // ****************************************
   // Pin-sourced features
   // ****************************************
   always_comb begin
      pin_features = '0;
      pin_features.ddr_en = rate_pin_float;
      pin_features.ddr_phase_90 = 1'b0;
      pin_features.sdr_rising_edge = rate_pin_high;
      pin_features.swing_normal = output_swing_sel;
      pin_features.cal_delay_long = delay_pin_high;
      pin_features.duty_stab_en = 1'b1;
      // range pin, same for both channels
      pin_features.fs_from_pin = 1'b1;
      pin_features.fs_pin_high = range_pin_high;
      pin_features.offset_en = 1'b0;
      pin_features.offset_code_i = control_mode_pkg::ZERO_ADJ;
      pin_features.offset_code_q = control_mode_pkg::ZERO_ADJ;
      pin_features.des_en = delay_pin_float;
      pin_features.des_q_channel = 1'b0;
      pin_features.des_auto_phase = 1'b1;
   end

   // ****************************************
   // Register-sourced features
   // ****************************************
   always_comb begin
      reg_features = '0;
      reg_features.ddr_en = ~cfg[control_mode_pkg::CFG_DDR_OFF_BIT];
      reg_features.ddr_phase_90 = cfg[control_mode_pkg::CFG_DDR_PHASE_BIT];
      reg_features.sdr_rising_edge = cfg[control_mode_pkg::CFG_OE_BIT];
      reg_features.swing_normal = cfg[control_mode_pkg::CFG_SWING_BIT];
      reg_features.cal_delay_long = 1'b0;
      reg_features.duty_stab_en = cfg[control_mode_pkg::CFG_DCS_BIT];
      reg_features.fs_from_pin = 1'b0;
      reg_features.fs_code_i =
         regs[control_mode_pkg::ADDR_FS_I][control_mode_pkg::ADJ_MSB:control_mode_pkg::ADJ_LSB];
      reg_features.fs_code_q =
         regs[control_mode_pkg::ADDR_FS_Q][control_mode_pkg::ADJ_MSB:control_mode_pkg::ADJ_LSB];
      reg_features.offset_en = 1'b1;
      reg_features.offset_code_i =
         regs[control_mode_pkg::ADDR_OFFSET_I][control_mode_pkg::ADJ_MSB:control_mode_pkg::ADJ_LSB];
      reg_features.offset_code_q =
         regs[control_mode_pkg::ADDR_OFFSET_Q][control_mode_pkg::ADJ_MSB:control_mode_pkg::ADJ_LSB];
      reg_features.des_en = des[control_mode_pkg::DES_EN_BIT];
      reg_features.des_q_channel = des[control_mode_pkg::DES_QSEL_BIT];
      reg_features.des_auto_phase = des[control_mode_pkg::DES_AUTO_BIT];
      reg_features.phase_coarse = regs[control_mode_pkg::ADDR_COARSE];
      reg_features.phase_fine = regs[control_mode_pkg::ADDR_FINE];
   end

   // ****************************************
   // Global select and outputs
   // ****************************************
   // one multiplexer on the latched mode
   assign next_features = is_extended ? reg_features : pin_features;

   // Registered outputs; follow pin-sourced features until mode settles
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         features <= '0;
         mode_valid <= 1'b0;
         mode_extended <= 1'b0;
      end else begin
         features <= next_features;
         mode_valid <= is_extended || mode == control_mode_pkg::MODE_NORMAL;
         mode_extended <= is_extended;
      end
   end

endmodule // control_mode_config_select

`default_nettype wire

// *** verif/control_mode_chk.sv ***
// Port checker for the control mode select block.
// Assumes one clock domain and a synchronous active low reset.
`default_nettype none

module control_mode_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [control_mode_pkg::NUM_TRI_PINS-1:0] pin_sense_high,
   input wire logic [control_mode_pkg::NUM_TRI_PINS-1:0] pin_sense_low,
   input wire logic output_swing_sel,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic serial_select_n,
   input wire logic mode_valid,
   input wire logic mode_extended,
   input wire control_mode_pkg::feature_s features
);
   timeunit 1ns;
   timeprecision 1ns;

   // ********************
   // Pad levels and mode
   // ********************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // Floating and driven high pads, latched modes
   wire logic [2:0] flt = ~(pin_sense_high ^ pin_sense_low);
   wire logic [2:0] hi = pin_sense_high & ~pin_sense_low;
   wire logic nrm = mode_valid && !mode_extended;
   wire logic ext = mode_valid && mode_extended;

   // ********************
   // Assertions
   // ********************
   mode_latch_a: assert property (mode_valid |=> mode_valid && $stable(mode_extended))
      else $error("mode changed after latch");
   mode_pick_a: assert property ($rose(mode_valid) |-> mode_extended == flt[0])
      else $error("mode differs from range pin");
   norm_rate_a: assert property (nrm |-> features.ddr_en == $past(flt[1], 2))
      else $error("rate differs from pin");
   norm_edge_a: assert property (nrm && !features.ddr_en |-> features.sdr_rising_edge == $past(hi[1], 2))
      else $error("edge differs from pin");
   norm_swing_a: assert property (nrm |-> features.swing_normal == $past(output_swing_sel, 2))
      else $error("swing differs from pin");
   norm_delay_a: assert property (nrm |->
      {features.cal_delay_long, features.des_en} == $past({hi[2], flt[2]}, 2))
      else $error("delay pin decode wrong");
   norm_fixed_a: assert property (nrm |->
      !features.ddr_phase_90 && !features.offset_en && !features.des_q_channel)
      else $error("fixed normal setting wrong");
   norm_regs_a: assert property (nrm |->
      features.phase_coarse == 16'h0000 && features.phase_fine == 16'h0000)
      else $error("register reached normal mode");
   ext_delay_a: assert property (ext |-> !features.cal_delay_long)
      else $error("long delay in extended mode");
   ext_hold_a: assert property ((ext && serial_select_n) [*5] |=> $stable(features))
      else $error("features moved without a frame");
endmodule // control_mode_chk

bind control_mode_config_select control_mode_chk u_chk (.sys_clk, .rst_n, .pin_sense_high, .pin_sense_low,
   .output_swing_sel, .serial_clk, .serial_data, .serial_select_n, .mode_valid, .mode_extended, .features);

`default_nettype wire

// *** verif/host_link_model.sv ***
// Host side of the three-wire write-only link.
// Assumes the bench calls send between clock edges of sys_clk.
`default_nettype none

module host_link_model (
   input wire logic sys_clk,
   output logic serial_clk,
   output logic serial_data,
   output logic serial_select_n
);
   timeunit 1ns;
   timeprecision 1ns;

   // ********************
   // Frame sender
   // ********************
   // Idle link: clock still, select high
   initial begin
      serial_clk = 1'h0;
      serial_data = 1'h1;
      serial_select_n = 1'h1;
   end

   // msb first frame
   // Each half of a bit lasts h clocks; k keeps select low
   task automatic send(input logic [11:0] hdr, input logic [3:0] a, input logic [15:0] d,
      input int h, input logic k);
      logic [31:0] f;
      f = {hdr, a, d};
      for (int i = 31; i >= 0; i--) begin
         @(posedge sys_clk);
         serial_select_n <= 1'h0;
         serial_clk <= 1'h0;
         serial_data <= f[i];
         repeat (h) @(posedge sys_clk);
         serial_clk <= 1'h1;
         repeat (h - 1) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      serial_clk <= 1'h0;
      serial_data <= ~f[0]; // Released line shows no stale bit
      if (!k) begin
         serial_select_n <= 1'h1;
      end
   endtask
endmodule // host_link_model

`default_nettype wire

// *** verif/control_mode_config_select_bench.sv ***
// Bench for the control mode select block: strap table, then extended register writes.
// Assumes the host link model drives the serial pins and the checker is bound.
`default_nettype none

module control_mode_config_select_bench;
   timeunit 1ns;
   timeprecision 1ns;

   // ********************
   // Clock, straps, design
   // ********************
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [2:0] sense_high = 3'h0;
   logic [2:0] sense_low = 3'h0;
   logic swing = 1'h0;
   wire logic sclk, sdat, ssel_n, mode_valid, mode_extended;
   control_mode_pkg::feature_s features;
   int n_fail = 0;
   int total_checks = 0;
   always #25 sys_clk = ~sys_clk;

   control_mode_config_select u_dut (.sys_clk, .rst_n, .pin_sense_high(sense_high), .pin_sense_low(sense_low),
      .output_swing_sel(swing), .serial_clk(sclk), .serial_data(sdat), .serial_select_n(ssel_n), .mode_valid,
      .mode_extended, .features);
   host_link_model u_host (.sys_clk, .serial_clk(sclk), .serial_data(sdat), .serial_select_n(ssel_n));

   // Normal mode rows: pads, swing, expected flags, range flag
   typedef struct packed {
      control_mode_pkg::pin_level_e m, r, d;
      logic sw;
      logic [10:0] v;
      logic fsh;
   } row_s;
   row_s rows [4] = '{
      '{control_mode_pkg::PIN_LOW, control_mode_pkg::PIN_FLOAT, control_mode_pkg::PIN_LOW, 1'h1, 11'h251, 1'h0},
      '{control_mode_pkg::PIN_HIGH, control_mode_pkg::PIN_HIGH, control_mode_pkg::PIN_HIGH, 1'h0, 11'h0B1, 1'h1},
      '{control_mode_pkg::PIN_HIGH, control_mode_pkg::PIN_LOW, control_mode_pkg::PIN_FLOAT, 1'h1, 11'h055, 1'h1},
      '{control_mode_pkg::PIN_LOW, control_mode_pkg::PIN_HIGH, control_mode_pkg::PIN_LOW, 1'h1, 11'h0D1, 1'h0}};

   // ********************
   // Tasks
   // ********************
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check_w(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Flags: mode, ddr, phase, rise, swing, delay, pin range, offset, des, q, auto
   task automatic check_f(input logic [10:0] exp);
      check_w({5'h00, mode_extended, features.ddr_en, features.ddr_phase_90, features.sdr_rising_edge,
         features.swing_normal, features.cal_delay_long, features.fs_from_pin, features.offset_en,
         features.des_en, features.des_q_channel, features.des_auto_phase}, {5'h00, exp});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic strap(input control_mode_pkg::pin_level_e m, r, d, input logic sw);
      control_mode_pkg::pin_level_e lv [3];
      lv = '{m, r, d};
      @(posedge sys_clk);
      for (int i = 0; i < 3; i++) begin
         sense_high[i] <= (lv[i] == control_mode_pkg::PIN_HIGH);
         sense_low[i] <= (lv[i] == control_mode_pkg::PIN_LOW);
      end
      swing <= sw;
   endtask

   // Straps change only under reset, then wait for the mode latch
   task automatic restart(input control_mode_pkg::pin_level_e m, r, d, input logic sw);
      int n;
      n = 0;
      @(posedge sys_clk);
      rst_n <= 1'h0;
      strap(m, r, d, sw);
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'h1;
      while (mode_valid !== 1'h1 && n < 30) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 30) begin
         n_fail++;
         $display("Error at %0t: mode never valid", $time);
         final_report();
      end
      settle(3);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d, input int h, input logic k);
      u_host.send(control_mode_pkg::FRAME_HEADER, a, d, h, k);
      if (!k) begin
         settle(4);
      end
   endtask

   // ********************
   // Sequence
   // ********************
   initial begin
      foreach (rows[i]) begin
         restart(rows[i].m, rows[i].r, rows[i].d, rows[i].sw);
         check_f(rows[i].v);
         check_w({15'h0000, features.fs_pin_high}, {15'h0000, rows[i].fsh});
      end
      wr(control_mode_pkg::ADDR_CONFIG, 16'hBAFF, 1, 1'h0);
      check_f(11'h0D1);
      restart(control_mode_pkg::PIN_FLOAT, control_mode_pkg::PIN_HIGH, control_mode_pkg::PIN_HIGH, 1'h0);
      check_f(11'h64A);
      check_w({7'h00, features.fs_code_i}, 16'h0100);
      check_w({7'h00, features.offset_code_i}, 16'h0000);
      check_w({6'h00, features.duty_stab_en, features.fs_code_q}, 16'h0300);
      check_w({7'h00, features.offset_code_q}, 16'h0000);
      strap(control_mode_pkg::PIN_FLOAT, control_mode_pkg::PIN_FLOAT, control_mode_pkg::PIN_LOW, 1'h1);
      settle(3);
      check_f(11'h64A);
      wr(control_mode_pkg::ADDR_CONFIG, 16'hB5FF, 1, 1'h0);
      check_f(11'h48A);
      u_host.send(12'h002, control_mode_pkg::ADDR_CONFIG, 16'hBAFF, 1, 1'h0);
      settle(4);
      check_f(11'h48A);
      wr(4'h4, 16'hBAFF, 1, 1'h0);
      check_f(11'h48A);
      wr(control_mode_pkg::ADDR_CONFIG, 16'hBAFF, 3, 1'h0);
      check_f(11'h74A);
      wr(control_mode_pkg::ADDR_FS_I, 16'hFF80, 1, 1'h1);
      wr(control_mode_pkg::ADDR_OFFSET_I, 16'h0080, 1, 1'h0);
      check_w({7'h00, features.fs_code_i}, 16'h01FF);
      check_w({7'h00, features.offset_code_i}, 16'h0001);
      wr(control_mode_pkg::ADDR_DES, 16'hDFFF, 1, 1'h0);
      check_f(11'h74D);
      wr(control_mode_pkg::ADDR_COARSE, 16'h1234, 1, 1'h1);
      wr(control_mode_pkg::ADDR_FINE, 16'h00A5, 1, 1'h0);
      check_w(features.phase_coarse, 16'h1234);
      check_w(features.phase_fine, 16'h00A5);
      final_report();
   end
endmodule // control_mode_config_select_bench

`default_nettype wire
